//--- hdl/event_interrupt_aggregator.sv
// event interrupt aggregator: latched events, status readback and open-drain interrupt
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "irq_agg_consts.svh"
// Functional notes
// - the I and Q datapath test failures are chip events on bits 1:0 of enable 0x020 and status 0x024.
// - the interrupt pin is open drain, active low, only ever pulled low.
// - a latched bit is held at zero while its enable is low.
// - with the enable high each rising edge of the event sets the latched bit until cleared.
// - the pin is pulled low while any latched bit of any block is set.
// - a clear strobe clears its latched bit and device reset clears them all.
// - status reads give raw event, latched bit or zero as the block's readback select says.
// - the blocks together cover 56 events (8 chip, 16 link, 32 lane), the count set by parameters.
// - chip status reads give the latched bit when enabled, else the live event.
// - link and lane status reads give the latched bit when enabled, else zero.
// - chip enables are read/write, chip status is write-one-to-clear, select follows enable.
// - link enables sit in two registers, clears and per-chip status in the next two, select one.
// - lane block of four registers takes enables per type, clears per link, status per link.
module event_interrupt_aggregator #(
	parameter int CHIP_N = `CHIP_EV_N,
	parameter int LINK_N = `LINK_EV_N,
	parameter int LANE_N = `LANE_EV_N
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [`DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output irq_agg_pkg::reg_byte_t reg_rdata,
	input wire logic datapath_test_sequence_fail_i,
	input wire logic datapath_test_sequence_fail_q,
	input wire logic [CHIP_N-3:0] chip_event_in,
	input wire logic [LINK_N-1:0] link_event_in,
	input wire logic [LANE_N-1:0] lane_event_in,
	input wire logic interrupt_out_n_in,
	output logic interrupt_out_n_out,
	output logic interrupt_out_n_oe,
	output logic agg_irq
);
	import irq_agg_pkg::*;

	localparam int EV_N = CHIP_N + LINK_N + LANE_N;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_meta_q;
	logic rst_sync_q;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	wire logic rst_n = rst_sync_q;

	// ----------------------------------------
	// event synchronisers and edge detect
	// ----------------------------------------
	logic [EV_N-1:0] ev_raw;
	logic [EV_N-1:0] ev_meta_q;
	logic [EV_N-1:0] ev_sync_q;
	logic [EV_N-1:0] ev_prev_q;
	logic [EV_N-1:0] ev_rise;
	assign ev_raw = {lane_event_in, link_event_in, chip_event_in,
		datapath_test_sequence_fail_q, datapath_test_sequence_fail_i};

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_meta_q <= '0;
			ev_sync_q <= '0;
			ev_prev_q <= '0;
		end else begin
			ev_meta_q <= ev_raw;
			ev_sync_q <= ev_meta_q;
			ev_prev_q <= ev_sync_q;
		end
	end
	assign ev_rise = ev_sync_q & ~ev_prev_q;

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [1:0] lane_idx(input logic [`ADDR_W-1:0] a);
		lane_idx = a[1:0];
	endfunction

	function automatic logic in_lane(input logic [`ADDR_W-1:0] a);
		in_lane = (a >= `OFF_LANE_0) && (a <= `OFF_LANE_3);
	endfunction

	// ----------------------------------------
	// enables
	// ----------------------------------------
	logic [EV_N-1:0] en_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= '0;
		end else if (reg_wr) begin
			if (hit(reg_addr, `OFF_CHIP_EN)) begin
				en_q[CHIP_N-1:0] <= reg_wdata[CHIP_N-1:0];
			end else if (hit(reg_addr, `OFF_LINK_EN_0)) begin
				en_q[CHIP_N +: 8] <= reg_wdata;
			end else if (hit(reg_addr, `OFF_LINK_EN_1)) begin
				en_q[CHIP_N+8 +: 8] <= reg_wdata;
			end else if (in_lane(reg_addr)) begin
				// lane bytes carry enable and clear at once; a set bit enables and clears
				en_q[CHIP_N+LINK_N+8*lane_idx(reg_addr) +: 8] <= reg_wdata;
			end
		end
	end

	// ----------------------------------------
	// clear strobes
	// ----------------------------------------
	logic [EV_N-1:0] clr;
	always_comb begin
		clr = '0;
		if (reg_wr) begin
			if (hit(reg_addr, `OFF_CHIP_STAT)) begin
				clr[CHIP_N-1:0] = reg_wdata[CHIP_N-1:0];
			end else if (hit(reg_addr, `OFF_LINK_ST_0)) begin
				clr[CHIP_N +: 8] = reg_wdata;
			end else if (hit(reg_addr, `OFF_LINK_ST_1)) begin
				clr[CHIP_N+8 +: 8] = reg_wdata;
			end else if (in_lane(reg_addr)) begin
				clr[CHIP_N+LINK_N+8*lane_idx(reg_addr) +: 8] = reg_wdata;
			end
		end
	end

	// ----------------------------------------
	// latched sources
	// ----------------------------------------
	// set beats clear so an edge landing on the clear cycle is kept
	logic [EV_N-1:0] src_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_q <= '0;
		end else begin
			src_q <= en_q & ((src_q & ~clr) | ev_rise);
		end
	end

	// ----------------------------------------
	// aggregator events: any chip, link, lane source
	// ----------------------------------------
	logic [`AGG_EV_N-1:0] agg_ev;
	logic [`AGG_EV_N-1:0] agg_stat_q;
	logic [`AGG_EV_N-1:0] agg_en_q;
	logic [`AGG_EV_N-1:0] agg_clr;
	assign agg_ev = {|(src_q[EV_N-1:CHIP_N+LINK_N]), |(src_q[CHIP_N+LINK_N-1:CHIP_N]),
		|(src_q[CHIP_N-1:0])};
	assign agg_clr = (reg_wr && hit(reg_addr, `OFF_AGG_CLR)) ? reg_wdata[`AGG_EV_N-1:0] : '0;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			agg_stat_q <= '0;
		end else begin
			agg_stat_q <= (agg_stat_q & ~agg_clr) | agg_ev;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			agg_en_q <= '0;
		end else if (reg_wr && hit(reg_addr, `OFF_AGG_EN)) begin
			agg_en_q <= reg_wdata[`AGG_EV_N-1:0];
		end
	end

	// ----------------------------------------
	// interrupt outputs
	// ----------------------------------------
	// pin driven low only; the output value is a constant zero so it never drives high
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_out_n_oe <= 1'b0;
			agg_irq <= 1'b0;
		end else begin
			interrupt_out_n_oe <= |src_q;
			agg_irq <= |(agg_stat_q & agg_en_q);
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_out_n_out <= 1'b0;
		end else begin
			interrupt_out_n_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// readback
	// ----------------------------------------
	logic [EV_N-1:0] stat_view;
	always_comb begin
		stat_view = src_q & en_q;
		for (int i = 0; i < CHIP_N; i++) begin
			stat_view[i] = en_q[i] ? src_q[i] : ev_sync_q[i];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (hit(reg_addr, `OFF_CHIP_EN)) begin
				reg_rdata <= en_q[CHIP_N-1:0];
			end else if (hit(reg_addr, `OFF_CHIP_STAT)) begin
				reg_rdata <= stat_view[CHIP_N-1:0];
			end else if (hit(reg_addr, `OFF_LINK_ST_0)) begin
				reg_rdata <= stat_view[CHIP_N +: 8];
			end else if (hit(reg_addr, `OFF_LINK_ST_1)) begin
				reg_rdata <= stat_view[CHIP_N+8 +: 8];
			end else if (in_lane(reg_addr)) begin
				reg_rdata <= stat_view[CHIP_N+LINK_N+8*lane_idx(reg_addr) +: 8];
			end else if (hit(reg_addr, `OFF_AGG_STAT)) begin
				reg_rdata <= {5'h00, agg_stat_q};
			end else if (hit(reg_addr, `OFF_AGG_EN)) begin
				reg_rdata <= {5'h00, agg_en_q};
			end else begin
				reg_rdata <= 8'h00;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_disabled_zero;
		@(posedge sys_clk) disable iff (!rst_n)
		!en_q[0] |=> !src_q[0] || en_q[0];
	endproperty
	a_disabled_zero: assert property (p_disabled_zero) else $error("source set while disabled");

	property p_edge_sets;
		@(posedge sys_clk) disable iff (!rst_n)
		ev_rise[0] && en_q[0] |=> src_q[0] || !en_q[0];
	endproperty
	a_edge_sets: assert property (p_edge_sets) else $error("enabled edge not latched");

	property p_sticky;
		@(posedge sys_clk) disable iff (!rst_n)
		src_q[1] && en_q[1] && !clr[1] |=> src_q[1] || !en_q[1];
	endproperty
	a_sticky: assert property (p_sticky) else $error("source dropped without clear");

	property p_pin_low;
		@(posedge sys_clk) disable iff (!rst_n)
		|src_q |=> interrupt_out_n_oe;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("pin not pulled with source set");

	property p_pin_release;
		@(posedge sys_clk) disable iff (!rst_n)
		!(|src_q) |=> !interrupt_out_n_oe;
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("pin pulled with no source");

	property p_never_high;
		@(posedge sys_clk) disable iff (!rst_n)
		interrupt_out_n_oe |-> !interrupt_out_n_out;
	endproperty
	a_never_high: assert property (p_never_high) else $error("interrupt pin driven high");

	property p_clear;
		@(posedge sys_clk) disable iff (!rst_n)
		clr[0] && !ev_rise[0] |=> !src_q[0];
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not clear");

	property p_chip_live;
		@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && hit(reg_addr, `OFF_CHIP_STAT) && !en_q[0] |=> reg_rdata[0] == $past(ev_sync_q[0]);
	endproperty
	a_chip_live: assert property (p_chip_live) else $error("chip status not live event");

	property p_link_zero;
		@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && hit(reg_addr, `OFF_LINK_ST_0) && !en_q[CHIP_N] |=> !reg_rdata[0];
	endproperty
	a_link_zero: assert property (p_link_zero) else $error("disabled link status not zero");

	property p_rdata_one;
		@(posedge sys_clk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rdata_one: assert property (p_rdata_one) else $error("read data outside read cycle");

	property p_line_low;
		@(posedge sys_clk) disable iff (!rst_n)
		interrupt_out_n_oe |-> !interrupt_out_n_in;
	endproperty
	a_line_low: assert property (p_line_low) else $error("line high while pulled");

	property p_src_en;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |-> (src_q & ~$past(en_q)) == '0;
	endproperty
	a_src_en: assert property (p_src_en) else $error("source set without enable");

	property p_link_set;
		@(posedge sys_clk) disable iff (!rst_n)
		ev_rise[CHIP_N] && en_q[CHIP_N] |=> src_q[CHIP_N];
	endproperty
	a_link_set: assert property (p_link_set) else $error("link edge not latched");

	property p_lane_set;
		@(posedge sys_clk) disable iff (!rst_n)
		ev_rise[EV_N-1] && en_q[EV_N-1] |=> src_q[EV_N-1];
	endproperty
	a_lane_set: assert property (p_lane_set) else $error("lane edge not latched");

	property p_link_clr;
		@(posedge sys_clk) disable iff (!rst_n)
		clr[CHIP_N] && !ev_rise[CHIP_N] |=> !src_q[CHIP_N];
	endproperty
	a_link_clr: assert property (p_link_clr) else $error("link clear did not clear");

	property p_set_wins;
		@(posedge sys_clk) disable iff (!rst_n)
		clr[0] && ev_rise[0] && en_q[0] |=> src_q[0];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("edge lost to clear");

	property p_rise_once;
		@(posedge sys_clk) disable iff (!rst_n)
		ev_rise[0] |=> !ev_rise[0];
	endproperty
	a_rise_once: assert property (p_rise_once) else $error("one event seen twice");

	property p_lane_zero;
		@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && hit(reg_addr, `OFF_LANE_3) && !en_q[EV_N-1] |=> !reg_rdata[7];
	endproperty
	a_lane_zero: assert property (p_lane_zero) else $error("disabled lane status set");

	property p_chip_lat;
		@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && hit(reg_addr, `OFF_CHIP_STAT) && en_q[1] |=> reg_rdata[1] == $past(src_q[1]);
	endproperty
	a_chip_lat: assert property (p_chip_lat) else $error("chip status not latched");

	property p_en_read;
		@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && hit(reg_addr, `OFF_CHIP_EN) |=> reg_rdata == $past(en_q[CHIP_N-1:0]);
	endproperty
	a_en_read: assert property (p_en_read) else $error("chip enable readback wrong");

	property p_link_en_wo;
		@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && hit(reg_addr, `OFF_LINK_EN_0) |=> reg_rdata == 8'h00;
	endproperty
	a_link_en_wo: assert property (p_link_en_wo) else $error("write-only enable read back");

	property p_agg_irq;
		@(posedge sys_clk) disable iff (!rst_n)
		|(agg_stat_q & agg_en_q) |=> agg_irq;
	endproperty
	a_agg_irq: assert property (p_agg_irq) else $error("summary interrupt missing");

	c_fail_i: cover property (@(posedge sys_clk) disable iff (!rst_n) src_q[0] && interrupt_out_n_oe);
	c_lane: cover property (@(posedge sys_clk) disable iff (!rst_n) |src_q[EV_N-1:CHIP_N+LINK_N]);
	c_clr_set: cover property (@(posedge sys_clk) disable iff (!rst_n) clr[0] && ev_rise[0]);
	c_agg_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) agg_irq);
endmodule

//--- include/irq_agg_consts.svh
// offsets, field positions, reset values and sizes of the event interrupt aggregator
`ifndef IRQ_AGG_CONSTS_SVH
`define IRQ_AGG_CONSTS_SVH
`define ADDR_W 12
`define DATA_W 8
`define OFF_CHIP_EN 12'h020
`define OFF_CHIP_STAT 12'h024
`define OFF_LANE_0 12'h470
`define OFF_LANE_3 12'h473
`define OFF_LINK_EN_0 12'h4B8
`define OFF_LINK_EN_1 12'h4B9
`define OFF_LINK_ST_0 12'h4BA
`define OFF_LINK_ST_1 12'h4BB
`define OFF_AGG_STAT 12'h4C0
`define OFF_AGG_CLR 12'h4C1
`define OFF_AGG_EN 12'h4C2
`define CHIP_EV_N 8
`define LINK_EV_N 16
`define LANE_EV_N 32
`define BIT_TEST_FAIL_I 0
`define BIT_TEST_FAIL_Q 1
`define RST_EN 8'h00
`define AGG_EV_N 3
`endif

//--- include/irq_agg_pkg.sv
// types of the event interrupt aggregator
package irq_agg_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef enum logic [2:0] {
		BLK_CHIP = 3'h1,
		BLK_LINK = 3'h2,
		BLK_LANE = 3'h4
	} block_kind_t;
endpackage

//--- test/irq_host_model.sv
// host side of the shared interrupt line: pull-up and sensed level
`timescale 1ns/1ps
module irq_host_model (
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic irq_line
);
	// the resistor wins only while no open-drain party pulls
	assign irq_line = pin_oe ? pin_out : 1'b1;
endmodule

//--- test/event_interrupt_aggregator_tb_top.sv
// testbench of the event interrupt aggregator
`timescale 1ns/1ps
`include "irq_agg_consts.svh"
module event_interrupt_aggregator_tb_top;
	import irq_agg_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	reg_byte_t reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	reg_byte_t reg_rdata;
	logic fail_i = 1'b0;
	logic fail_q = 1'b0;
	logic [5:0] chip_ev = 6'h00;
	logic [15:0] link_ev = 16'h0000;
	logic [31:0] lane_ev = 32'h00000000;
	logic pin_out;
	logic pin_oe;
	logic irq_line;
	logic agg_irq;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	always #5 sys_clk = ~sys_clk;
	event_interrupt_aggregator event_interrupt_aggregator_inst (
		.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.datapath_test_sequence_fail_i(fail_i), .datapath_test_sequence_fail_q(fail_q),
		.chip_event_in(chip_ev), .link_event_in(link_ev), .lane_event_in(lane_ev),
		.interrupt_out_n_in(irq_line), .interrupt_out_n_out(pin_out),
		.interrupt_out_n_oe(pin_oe), .agg_irq(agg_irq)
	);
	irq_host_model irq_host_model_inst (
		.pin_out(pin_out), .pin_oe(pin_oe), .irq_line(irq_line)
	);
	// ----------------------------------------
	// bus tasks, entered just after a rising edge
	// ----------------------------------------
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic chk(input reg_byte_t s, input reg_byte_t e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %0t ns: got %h expected %h", $time, s, e);
		end
	endtask
	// gap cycle after each strobe so no signal is assigned twice in a step
	task automatic wr(input logic [11:0] a, input reg_byte_t d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rc(input logic [11:0] a, input reg_byte_t e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
		@(posedge sys_clk);
	endtask
	task automatic pin(input logic e);
		#1 chk({7'h00, irq_line}, {7'h00, e});
	endtask
	task automatic summarize;
		if (error_cnt == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			summarize();
		end
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		wt(2);
		rst_b <= 1'b1;
		wt(3);
		rc(`OFF_CHIP_EN, `RST_EN);
		rc(12'h100, 8'h00);
		fail_i <= 1'b1;
		wt(4);
		rc(`OFF_CHIP_STAT, 8'h01);
		pin(1'b1);
		fail_i <= 1'b0;
		wt(3);
		wr(`OFF_CHIP_EN, 8'h03);
		fail_i <= 1'b1;
		fail_q <= 1'b1;
		wt(5);
		rc(`OFF_CHIP_STAT, 8'h03);
		pin(1'b0);
		fail_i <= 1'b0;
		fail_q <= 1'b0;
		wt(3);
		rc(`OFF_CHIP_STAT, 8'h03);
		wr(`OFF_CHIP_STAT, 8'h01);
		rc(`OFF_CHIP_STAT, 8'h02);
		// host service sequence on the remaining source
		rc(`OFF_CHIP_STAT, 8'h02);
		wr(`OFF_CHIP_EN, 8'h00);
		rc(`OFF_CHIP_STAT, 8'h00);
		pin(1'b1);
		wr(`OFF_CHIP_STAT, 8'h03);
		wr(`OFF_CHIP_EN, 8'h03);
		rc(`OFF_CHIP_STAT, 8'h00);
		pin(1'b1);
		// event edge and clear strobe land on the same edge: the set wins
		fail_i <= 1'b1;
		wt(2);
		wr(`OFF_CHIP_STAT, 8'h01);
		rc(`OFF_CHIP_STAT, 8'h01);
		fail_i <= 1'b0;
		wr(`OFF_CHIP_STAT, 8'h01);
		rc(`OFF_CHIP_STAT, 8'h00);
		link_ev[0] <= 1'b1;
		wt(4);
		rc(`OFF_LINK_ST_0, 8'h00);
		link_ev[0] <= 1'b0;
		wt(3);
		wr(`OFF_LINK_EN_0, 8'h01);
		link_ev[0] <= 1'b1;
		wt(5);
		rc(`OFF_LINK_ST_0, 8'h01);
		rc(`OFF_LINK_EN_0, 8'h00);
		pin(1'b0);
		wr(`OFF_LINK_ST_0, 8'h01);
		rc(`OFF_LINK_ST_0, 8'h00);
		link_ev[0] <= 1'b0;
		wr(`OFF_LANE_3, 8'h80);
		lane_ev[31] <= 1'b1;
		wt(5);
		rc(`OFF_LANE_3, 8'h80);
		rc(`OFF_LANE_0, 8'h00);
		wr(`OFF_AGG_EN, 8'h04);
		rc(`OFF_AGG_STAT, 8'h07);
		#1 chk({7'h00, agg_irq}, 8'h01);
		wr(`OFF_AGG_CLR, 8'h03);
		rc(`OFF_AGG_STAT, 8'h04);
		wr(`OFF_LINK_EN_1, 8'h80);
		link_ev[15] <= 1'b1;
		wt(5);
		rc(`OFF_LINK_ST_1, 8'h80);
		wr(`OFF_LINK_ST_1, 8'h80);
		rc(`OFF_LINK_ST_1, 8'h00);
		link_ev[15] <= 1'b0;
		lane_ev[31] <= 1'b0;
		// mid-run device reset drops every latched source
		rst_b <= 1'b0;
		wt(2);
		pin(1'b1);
		rst_b <= 1'b1;
		wt(3);
		rc(`OFF_LANE_3, 8'h00);
		rc(`OFF_AGG_EN, 8'h00);
		rc(`OFF_CHIP_EN, `RST_EN);
		pin(1'b1);
		summarize();
	end
endmodule
